// file: pkg/avt_pkg.sv
package avt_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ        = 200_000_000; // clk_sys rate
	localparam int unsigned KEY_HOLD_MS   = 5000;        // key hold time
	localparam int unsigned HOLD_DELAY_MS = 100;         // full power time
	localparam int unsigned WDOG_MS       = 1000;        // command watchdog
	localparam int unsigned TEACH_TMO_MS  = 10000;       // travel timeout
	// cycle counts (per-ms count rounds down, all exact here)
	localparam longint KEY_HOLD_CYC  = (longint'(CLK_HZ) / 1000) * KEY_HOLD_MS;
	localparam longint HOLD_CYC      = (longint'(CLK_HZ) / 1000) * HOLD_DELAY_MS;
	localparam longint WDOG_CYC      = (longint'(CLK_HZ) / 1000) * WDOG_MS;
	localparam longint TEACH_TMO_CYC = (longint'(CLK_HZ) / 1000) * TEACH_TMO_MS;
	localparam int unsigned BLINK_CYC   = 20_000_000; // 0.1 s half period
	localparam int unsigned FLICKER_CYC = 2_000_000;  // 10 ms half period
	// ==========================================
	// data bit positions
	localparam int TOP_REACHED_POS    = 3; // input data
	localparam int BOTTOM_REACHED_POS = 2; // input data
	localparam int PILOT_CMD_POS      = 0; // output data
	localparam int TEACH_CTRL_POS     = 0; // parameter
	// reset values
	localparam logic [3:0] PARAM_RST  = 4'hf; // teach stop
	localparam logic [3:0] OUTDAT_RST = 4'h0;
	// identification, values arbitrary
	localparam logic [3:0] IO_CFG_DEF  = 4'h1;
	localparam logic [3:0] ID_CODE_DEF = 4'h2;
	localparam logic [3:0] EXT_ID1_DEF = 4'h3;
	localparam logic [3:0] EXT_ID2_DEF = 4'h4;
	// ==========================================
	typedef struct packed {
		logic [3:0] io_cfg;
		logic [3:0] id_code;
		logic [3:0] ext_id1;
		logic [3:0] ext_id2;
	} avt_ident_t;
	typedef struct packed {
		logic teach_busy;
		logic status_led;
		logic valve_led;
		logic teach_fail;
	} avt_status_t;
endpackage : avt_pkg

// file: hdl/avt_sync.sv
`timescale 1ns/1ps
// ==========================================
// two-flop synchroniser for pin levels
module avt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by dout
	// two stages, first never fans out
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : avt_sync

// file: hdl/avt_valve_slave.sv
`timescale 1ns/1ps
// ==========================================
// valve slave application logic
// Notes on behaviour
// - input bit3 top, bit2 bottom reached
// - output bit0 energizes pilot valve
// - parameter bit0 0 starts, 1 stops
// - teach start accepted from bus
// - key held five seconds starts teach
// - bottom, valve on, top, valve off
// - bus valve commands ignored while teaching
// - reduced power after 100 ms, watchdog
// - fixed identification codes
// - status LED flashes teaching, flickers missing
// - valve LED lit when energized
module avt_valve_slave
#(
	parameter longint KEY_CYC  = avt_pkg::KEY_HOLD_CYC,
	parameter longint PWR_CYC  = avt_pkg::HOLD_CYC,
	parameter longint DOG_CYC  = avt_pkg::WDOG_CYC,
	parameter longint TMO_CYC  = avt_pkg::TEACH_TMO_CYC,
	parameter int     BLK_CYC  = avt_pkg::BLINK_CYC,
	parameter int     FLK_CYC  = avt_pkg::FLICKER_CYC
) (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic [3:0]      out_data,      // master output data
	input  wire logic            out_strobe,    // out_data valid pulse
	input  wire logic [3:0]      param_data,    // master parameter
	input  wire logic            param_strobe,  // param valid pulse
	input  wire logic            top_pin,       // limit switch top
	input  wire logic            bot_pin,       // limit switch bottom
	input  wire logic            key_pin,       // local teach key
	input  wire logic            target_pin,    // target element present
	output logic      [3:0]      in_data,       // to master
	output avt_pkg::avt_ident_t  ident,         // identification codes
	output logic                 valve_output,  // pilot valve drive
	output logic                 valve_reduced, // holding power
	output logic                 wdog_trip,     // watchdog expired
	output avt_pkg::avt_status_t status,        // status flags
	output logic                 top_stored,    // taught top valid
	output logic                 bot_stored     // taught bottom valid
);
	import avt_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE, ST_CAP_BOT, ST_RISE, ST_CAP_TOP, ST_FALL
	} avt_state_t;
	avt_state_t  st_q;
	logic        top_s, bot_s, key_s, tgt_s; // synced pins
	logic        valve_cmd_q;     // bus command after gating
	logic        drive_d;         // wanted valve level
	logic [39:0] key_cnt_q;       // key hold counter
	logic [39:0] pwr_cnt_q;       // energized time
	logic [39:0] dog_cnt_q;       // time since last out_strobe
	logic [39:0] tmo_cnt_q;       // travel timeout
	logic [31:0] blk_cnt_q;       // led timebase
	logic        blk_q, flk_q;
	logic        bus_start, bus_stop, key_start;
	logic        bot_tmp_q;       // bottom captured this run
	logic        busy_q, sled_q;  // teach busy, status led
	logic        vled_q, fail_q;  // valve led, teach fault
	// status fields come straight from these flops, one writer each
	assign status = {busy_q, sled_q, vled_q, fail_q};
	// ==========================================
	// pin synchronisation
	avt_sync #(.W(4)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({top_pin, bot_pin, key_pin, target_pin}),
		.dout    ({top_s, bot_s, key_s, tgt_s})
	);
	// teach triggers; stop is ignored while idle, so a key start in the same cycle still wins
	assign bus_start = param_strobe && !param_data[TEACH_CTRL_POS];
	assign bus_stop  = param_strobe && param_data[TEACH_CTRL_POS];
	assign key_start = key_s && (key_cnt_q == KEY_CYC[39:0] - 40'h1);
	// ==========================================
	// key hold timer, released key restarts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			key_cnt_q <= 40'h0;
		end else if (!key_s) begin
			key_cnt_q <= 40'h0; // short press lost
		end else if (key_cnt_q < KEY_CYC[39:0]) begin
			key_cnt_q <= key_cnt_q + 40'h1;
		end
	end
	// ==========================================
	// teach sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q       <= ST_IDLE;
			tmo_cnt_q  <= 40'h0;
			bot_tmp_q  <= 1'b0;
			top_stored <= 1'b0;
			bot_stored <= 1'b0;
			fail_q     <= 1'b0;
		end else begin
			tmo_cnt_q <= (st_q == ST_RISE || st_q == ST_FALL) ?
				tmo_cnt_q + 40'h1 : 40'h0;
			if (bus_stop && st_q != ST_IDLE) begin
				st_q <= ST_IDLE; // abort, stored kept
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (bus_start || key_start) begin
							st_q   <= ST_CAP_BOT;
							fail_q <= 1'b0;
						end
					end
					ST_CAP_BOT: begin
						bot_tmp_q <= bot_s;
						st_q      <= ST_RISE;
					end
					ST_RISE: begin // valve on, wait top
						if (top_s) begin
							st_q <= ST_CAP_TOP;
						end else if (tmo_cnt_q >= TMO_CYC[39:0]) begin
							st_q <= ST_IDLE;
							fail_q <= 1'b1; // travel timed out
						end
					end
					ST_CAP_TOP: begin // commit both
						top_stored <= 1'b1;
						bot_stored <= bot_tmp_q;
						st_q       <= ST_FALL;
					end
					ST_FALL: begin // valve off, return home
						if (bot_s || tmo_cnt_q >= TMO_CYC[39:0]) begin
							st_q <= ST_IDLE;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
	// ==========================================
	// bus valve command, frozen during teach except for a watchdog trip
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			valve_cmd_q <= OUTDAT_RST[PILOT_CMD_POS];
		end else if (out_strobe && st_q == ST_IDLE) begin
			// fresh traffic outranks the trip: a returning master
			// must not lose its first command
			valve_cmd_q <= out_data[PILOT_CMD_POS]; // bit1 ignored
		end else if (wdog_trip) begin
			valve_cmd_q <= 1'b0; // lost master drops the valve
		end
	end
	always_comb begin
		drive_d = valve_cmd_q;
		if (st_q == ST_RISE || st_q == ST_CAP_TOP) begin
			drive_d = 1'b1;
		end else if (st_q != ST_IDLE) begin
			drive_d = 1'b0;
		end
		if (bus_stop && st_q != ST_IDLE) begin
			drive_d = 1'b0;
		end
	end
	// ==========================================
	// valve drive and power reduction
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			valve_output  <= 1'b0;
			valve_reduced <= 1'b0;
			pwr_cnt_q     <= 40'h0;
			vled_q        <= 1'b0;
		end else begin
			valve_output <= drive_d;
			vled_q       <= drive_d;
			if (!drive_d) begin
				pwr_cnt_q     <= 40'h0;
				valve_reduced <= 1'b0;
			end else if (pwr_cnt_q < PWR_CYC[39:0]) begin
				pwr_cnt_q <= pwr_cnt_q + 40'h1;
			end else begin
				valve_reduced <= 1'b1;
			end
		end
	end
	// ==========================================
	// watchdog on out_strobe traffic
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dog_cnt_q <= 40'h0;
			wdog_trip <= 1'b0;
		end else if (out_strobe) begin
			dog_cnt_q <= 40'h0;
			wdog_trip <= 1'b0;
		end else if (dog_cnt_q < DOG_CYC[39:0]) begin
			dog_cnt_q <= dog_cnt_q + 40'h1;
		end else begin
			wdog_trip <= 1'b1;
		end
	end
	// ==========================================
	// input data, identification, leds
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_data <= 4'h0;
			ident   <= '0;
			busy_q  <= 1'b0;
			sled_q  <= 1'b0;
		end else begin
			in_data <= 4'h0; // unused bits zero
			in_data[TOP_REACHED_POS]    <= top_s;
			in_data[BOTTOM_REACHED_POS] <= bot_s;
			ident <= '{IO_CFG_DEF, ID_CODE_DEF, EXT_ID1_DEF,
				EXT_ID2_DEF};
			busy_q <= (st_q != ST_IDLE);
			if (!tgt_s) begin
				sled_q <= flk_q; // missing target wins
			end else if (st_q != ST_IDLE) begin
				sled_q <= blk_q;
			end else begin
				sled_q <= 1'b0;
			end
		end
	end
	// blink and flicker timebase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			blk_cnt_q <= 32'h0;
			blk_q     <= 1'b0;
			flk_q     <= 1'b0;
		end else begin
			blk_cnt_q <= (blk_cnt_q >= 32'(BLK_CYC - 1)) ? 32'h0
				: blk_cnt_q + 32'h1;
			if (blk_cnt_q >= 32'(BLK_CYC - 1)) begin
				blk_q <= !blk_q;
			end
			if ((blk_cnt_q % 32'(FLK_CYC)) == 32'h0) begin
				flk_q <= !flk_q;
			end
		end
	end
	// ==========================================
	// checks
	chk_teach_freeze: assert property (@(posedge clk_sys) disable iff (rst)
		(st_q != ST_IDLE) |=> $stable(valve_cmd_q) || $past(wdog_trip))
		else $error("bus command changed during teach");
	chk_rise_drive: assert property (@(posedge clk_sys) disable iff (rst)
		(st_q == ST_RISE && !bus_stop) |=> valve_output)
		else $error("valve not energized while rising");
	chk_stop_abort: assert property (@(posedge clk_sys) disable iff (rst)
		(bus_stop && st_q != ST_IDLE) |=> st_q == ST_IDLE && !valve_output
		&& $stable(top_stored))
		else $error("stop did not abort teach");
	chk_top_report: assert property (@(posedge clk_sys) disable iff (rst)
		##1 in_data[TOP_REACHED_POS] == $past(top_s))
		else $error("top bit mismatch");
	chk_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
		in_data[1:0] == 2'h0)
		else $error("unused input bits set");
	chk_valve_led: assert property (@(posedge clk_sys) disable iff (rst)
		status.valve_led == valve_output)
		else $error("valve led mismatch");
	chk_reduce_time: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(valve_reduced) |-> pwr_cnt_q == PWR_CYC[39:0])
		else $error("reduction at wrong time");
	chk_short_key: assert property (@(posedge clk_sys) disable iff (rst)
		!key_s |=> key_cnt_q == 40'h0)
		else $error("key release kept hold time");
	chk_bus_start: assert property (@(posedge clk_sys) disable iff (rst)
		(st_q == ST_IDLE && bus_start) |=> st_q == ST_CAP_BOT)
		else $error("bus start not taken");
endmodule : avt_valve_slave

// file: tb/avt_far_model.sv
`timescale 1ns/1ps
// ==========================================
// bus master and actuator stand-in
module avt_far_model
#(
	parameter int TRAVEL = 20 // cycles from end to end
) (
	input  wire logic       clk_sys,
	input  wire logic       valve_output,
	output logic      [3:0] out_data,
	output logic            out_strobe,
	output logic      [3:0] param_data,
	output logic            param_strobe,
	output logic            top_pin,
	output logic            bot_pin
);
	import avt_pkg::*;
	int pos = 0;          // actuator stroke position
	logic stall = 1'b0;   // air lost: actuator cannot move
	initial begin
		out_data     = OUTDAT_RST;
		out_strobe   = 1'b0;
		param_data   = PARAM_RST;
		param_strobe = 1'b0;
	end
	// ==========================================
	// actuator: valve on drives up, off springs home
	always @(posedge clk_sys) begin
		#1;
		if (!stall && valve_output && pos < TRAVEL) pos++;
		if (!stall && !valve_output && pos > 0) pos--;
	end
	assign top_pin = (pos == TRAVEL);
	assign bot_pin = (pos == 0);
	// ==========================================
	// master writes: one-cycle strobe, data held as level
	task automatic put_out(input logic [3:0] d);
		@(posedge clk_sys);
		#1;
		out_data   = d;
		out_strobe = 1'b1;
		@(posedge clk_sys);
		#1;
		out_strobe = 1'b0;
	endtask : put_out
	task automatic put_param(input logic [3:0] d);
		@(posedge clk_sys);
		#1;
		param_data   = d;
		param_strobe = 1'b1;
		@(posedge clk_sys);
		#1;
		param_strobe = 1'b0;
	endtask : put_param
endmodule : avt_far_model

// file: tb/avt_valve_slave_tb.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the valve slave
module avt_valve_slave_tb;
	import avt_pkg::*;
	typedef struct packed {
		logic [3:0] cmd; // valve command sent
		logic       vo;  // expected valve drive
		logic [3:0] ind; // expected input data
	} avt_row_t;
	logic        clk_sys, rst, key_pin, target_pin;
	logic [3:0]  out_data, param_data, in_data;
	logic        out_strobe, param_strobe, top_pin, bot_pin;
	logic        valve_output, valve_reduced, wdog_trip;
	logic        top_stored, bot_stored;
	avt_ident_t  ident;
	avt_status_t status;
	int          err_total = 0;
	int          checks_done = 0;
	// bit1 must never move the valve
	avt_row_t rows [5] = '{'{4'h1, 1'b1, 4'h8}, '{4'h2, 1'b0, 4'h4},
		'{4'h3, 1'b1, 4'h8}, '{4'h0, 1'b0, 4'h4}, '{4'he, 1'b0, 4'h4}};
	// ==========================================
	// design and far side
	// flicker keeps its default, so here it paces with the blink
	avt_valve_slave #(.KEY_CYC(50), .PWR_CYC(20), .DOG_CYC(400),
		.TMO_CYC(100), .BLK_CYC(8)) DUT (.clk_sys(clk_sys),
		.rst(rst), .out_data(out_data), .out_strobe(out_strobe),
		.param_data(param_data), .param_strobe(param_strobe),
		.top_pin(top_pin), .bot_pin(bot_pin), .key_pin(key_pin),
		.target_pin(target_pin), .in_data(in_data), .ident(ident),
		.valve_output(valve_output), .valve_reduced(valve_reduced),
		.wdog_trip(wdog_trip), .status(status),
		.top_stored(top_stored), .bot_stored(bot_stored));
	avt_far_model m (.clk_sys(clk_sys), .valve_output(valve_output),
		.out_data(out_data), .out_strobe(out_strobe),
		.param_data(param_data), .param_strobe(param_strobe),
		.top_pin(top_pin), .bot_pin(bot_pin));
	// ==========================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	// bounded wait on the teach flag
	task automatic wait_busy(input logic v, input int n);
		for (int i = 0; i < n && status.teach_busy !== v; i++) cyc(1);
		chk("teach_busy", 16'(v), 16'(status.teach_busy));
	endtask : wait_busy
	// counts status led changes over 16 cycles
	task automatic chk_flips(input logic [15:0] e);
		logic        prev;
		logic [15:0] n;
		prev = status.status_led;
		n = 16'h0;
		for (int i = 0; i < 16; i++) begin
			cyc(1);
			if (status.status_led !== prev) begin
				n = n + 16'h1;
			end
			prev = status.status_led;
		end
		chk("status_led flips", e, n);
	endtask : chk_flips
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	// ==========================================
	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (4000) @(posedge clk_sys);
		err_total++;
		final_report();
	end
	// ==========================================
	// main sequence
	initial begin
		rst        = 1'b1;
		key_pin    = 1'b0;
		target_pin = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		cyc(4);
		chk("ident", {IO_CFG_DEF, ID_CODE_DEF, EXT_ID1_DEF, EXT_ID2_DEF},
			ident);
		chk("in_data", 16'h4, 16'(in_data));
		chk("stored", 16'h0, 16'({top_stored, bot_stored}));
		// ordinary valve commands from the table
		foreach (rows[i]) begin
			m.put_out(rows[i].cmd);
			cyc(5);
			chk("valve_reduced", 16'h0, 16'(valve_reduced));
			cyc(25);
			chk("valve_output", 16'(rows[i].vo), 16'(valve_output));
			chk("valve_reduced", 16'(rows[i].vo), 16'(valve_reduced));
			chk("valve_led", 16'(rows[i].vo), 16'(status.valve_led));
			chk("in_data", 16'(rows[i].ind), 16'(in_data));
		end
		// bus teach; upper parameter bits set but ignored
		m.put_param(4'he);
		wait_busy(1'b1, 10);
		cyc(1);
		chk("valve_output", 16'h1, 16'(valve_output));
		// an on command during teach must be dropped
		m.put_out(4'h1);
		cyc(3);
		chk("valve_output", 16'h1, 16'(valve_output));
		wait_busy(1'b0, 100);
		chk("stored", 16'h3, 16'({top_stored, bot_stored}));
		chk("valve_output", 16'h0, 16'(valve_output));
		cyc(30);
		// stop in mid-sequence keeps the stored positions
		m.put_param(4'h0);
		wait_busy(1'b1, 10);
		m.put_param(4'h1);
		wait_busy(1'b0, 5);
		cyc(2);
		chk("valve_output", 16'h0, 16'(valve_output));
		chk("stored", 16'h3, 16'({top_stored, bot_stored}));
		cyc(30);
		// short key press does nothing, long one starts teach
		m.put_out(4'h0);
		key_pin = 1'b1;
		cyc(30);
		key_pin = 1'b0;
		cyc(5);
		chk("teach_busy", 16'h0, 16'(status.teach_busy));
		key_pin = 1'b1;
		wait_busy(1'b1, 80);
		key_pin = 1'b0;
		wait_busy(1'b0, 100);
		cyc(30);
		// stuck actuator: travel times out, stored kept, led flashes
		m.stall = 1'b1;
		m.put_param(4'h0);
		wait_busy(1'b1, 10);
		chk_flips(16'h2);
		wait_busy(1'b0, 120);
		chk("teach_fail", 16'h1, 16'(status.teach_fail));
		chk("stored", 16'h3, 16'({top_stored, bot_stored}));
		chk("valve_output", 16'h0, 16'(valve_output));
		m.stall = 1'b0;
		// missing target element flickers the led while idle
		target_pin = 1'b0;
		cyc(4);
		chk_flips(16'h2);
		target_pin = 1'b1;
		cyc(4);
		chk_flips(16'h0);
		// reset in mid-run clears taught positions and fault
		rst = 1'b1;
		cyc(2);
		chk("stored", 16'h0, 16'({top_stored, bot_stored}));
		chk("teach_fail", 16'h0, 16'(status.teach_fail));
		chk("ident", 16'h0, 16'(ident));
		rst = 1'b0;
		cyc(4);
		chk("in_data", 16'h4, 16'(in_data));
		// command left energized, then the master falls silent
		m.put_out(4'h1);
		cyc(390);
		chk("wdog_trip", 16'h0, 16'(wdog_trip));
		chk("valve_output", 16'h1, 16'(valve_output));
		cyc(60);
		chk("wdog_trip", 16'h1, 16'(wdog_trip));
		chk("valve_output", 16'h0, 16'(valve_output));
		final_report();
	end
endmodule : avt_valve_slave_tb
